// ### hw/sau_top.sv
/*
 * one serial channel: uart, 3-wire clocked, or 4-wire slave with select.
 * assumes the array instantiates it per channel with CH_ODD set on odd
 * channels; pins are asynchronous and are synchronised here.
 */
`include "sau_defs.svh"
`default_nettype none
module sau_top #(
    parameter bit CH_ODD = 1'b0,
    parameter int PRS_W  = 4,
    parameter int DIV_W  = 7,
    parameter int MW     = 16
) (
    input  wire logic                sys_clk_i,
    input  wire logic                srst_i,
    input  wire sau_pkg::sau_mode_t  mode_i,
    input  wire logic                master_i,
    input  wire sau_pkg::sau_len_t   len_i,
    input  wire logic                msb_first_i,
    input  wire logic                cpol_i,
    input  wire logic                cpha_i,
    input  wire logic                invert_i,
    input  wire logic                par_en_i,
    input  wire logic                par_odd_i,
    input  wire logic                stop2_i,
    input  wire logic                irq_sel_i,
    input  wire logic                wake_en_i,
    input  wire logic [PRS_W-1:0]    prs_i,
    input  wire logic [DIV_W-1:0]    div_i,
    input  wire logic [8:0]          tx_data_i,
    input  wire logic                tx_valid_i,
    output logic                     tx_ready_o,
    output logic [8:0]               rx_data_o,
    output logic                     rx_valid_o,
    input  wire logic                rx_ready_i,
    input  wire logic [2:0]          err_clr_i,
    output logic [2:0]               err_o,
    output logic                     err_irq_o,
    output logic                     irq_o,
    input  wire logic                sdi_i,
    output logic                     sdo_o,
    input  wire logic                sck_i,
    output logic                     sck_o,
    output logic                     sck_oe_o,
    input  wire logic                ssel_n_i,
    output logic                     lin_rx_o,
    output logic                     lin_break_field_o,
    output logic                     wakeup_o,
    output logic [MW-1:0]            sync_val_o,
    output logic                     sync_done_o
);
    sau_pkg::sau_st_t st_q;
    logic [2:0] s1_q, s2_q, s3_q;
    logic [3:0] cnt_q, nbits;
    logic [8:0] sh_q, rxs_q, hold_q, mask;
    logic       ph_q, par_q, stopb_q, fin_q, tick;
    logic       uart, spi4, sync, slave, inv, rxl, rx_fall, sel;
    logic       lead, trail, samp, last, step, ubit, partx;
    logic       go_m, go_s, go_t, go_r, load, done, tx_end;
    logic [2:0] eset;
    logic [4:0] brk_q;
    logic [2:0] falls_q;
    logic       arm_q;
    logic [MW-1:0] meas_q;

    sau_stream_if #(.W(9)) rx_in ();
    sau_stream_if #(.W(9)) rx_out ();

    function automatic logic [3:0] bidx(input logic [3:0] c);
        bidx = msb_first_i ? 4'(nbits - 4'd1 - c) : c;
    endfunction

    // ==========================================================
    // pin synchronisers {data, clock, select}
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            s1_q <= 3'h7;
            s2_q <= 3'h7;
            s3_q <= 3'h7;
        end
        else
        begin
            s1_q <= {sdi_i, sck_i, ssel_n_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ==========================================================
    // mode decode
    assign uart    = mode_i == sau_pkg::MODE_UART;
    assign spi4    = mode_i == sau_pkg::MODE_4W;
    assign sync    = ~uart;
    assign slave   = sync & (spi4 | ~master_i);
    assign inv     = (uart | spi4) & invert_i;
    assign rxl     = s2_q[2] ^ inv;
    assign rx_fall = ~rxl & (s3_q[2] ^ inv);
    assign sel     = ~s2_q[0] | ~spi4;

    always_comb
    begin
        case (len_i)
            sau_pkg::LEN_7: nbits = `SAU_BITS7;
            sau_pkg::LEN_9: nbits = sync ? `SAU_BITS8 : `SAU_BITS9;
            default:        nbits = `SAU_BITS8;
        endcase
    end
    assign mask = `SAU_ONES9 >> (`SAU_BITS9 - nbits);

    // ==========================================================
    // clock edges and frame steps
    always_comb
    begin
        lead  = 1'b0;
        trail = 1'b0;
        if (slave)
        begin
            // synced edges; margin covers the two-flop lag
            lead  = sel & (cpol_i ? (~s2_q[1] & s3_q[1])
                                  : (s2_q[1] & ~s3_q[1]));
            trail = sel & (cpol_i ? (s2_q[1] & ~s3_q[1])
                                  : (~s2_q[1] & s3_q[1]));
        end
        else if (sync & tick & st_q == sau_pkg::ST_DATA)
        begin
            lead  = sck_o == cpol_i;
            trail = sck_o != cpol_i;
        end
    end
    assign samp = cpha_i ? trail : lead;
    assign last = cnt_q == 4'(nbits - 4'd1);
    assign step = uart & tick & ph_q;
    assign partx = ^(sh_q & mask) ^ par_odd_i;

    assign go_m = sync & ~slave & ~tx_ready_o;
    assign go_s = slave & sel;
    assign go_t = uart & ~CH_ODD & ~tx_ready_o;
    assign go_r = uart & CH_ODD & rx_fall;
    assign load = st_q == sau_pkg::ST_IDLE & (go_m | go_s | go_t);
    assign done = (sync & st_q == sau_pkg::ST_DATA & trail & last) |
                  (st_q == sau_pkg::ST_STOP & step &
                   (CH_ODD | ~stop2_i | cnt_q[0]));
    assign tx_end = done & uart & ~CH_ODD;

    sau_baud #(.PRS_W(PRS_W), .DIV_W(DIV_W)) u_baud (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .restart_i (st_q == sau_pkg::ST_IDLE & (go_m | go_t | go_r)),
        .run_i     (~slave),
        .prs_i     (prs_i),
        .div_i     (div_i),
        .tick_o    (tick)
    );

    // ==========================================================
    // sequencer
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            st_q  <= sau_pkg::ST_IDLE;
            cnt_q <= 4'h0;
        end
        else
        begin
            case (st_q)
                sau_pkg::ST_IDLE:
                begin
                    cnt_q <= 4'h0;
                    if (go_m | go_s)
                        st_q <= sau_pkg::ST_DATA;
                    else if (go_t | go_r)
                        st_q <= sau_pkg::ST_START;
                end
                sau_pkg::ST_START:
                    if (step)
                        st_q <= (CH_ODD & rxl) ? sau_pkg::ST_IDLE
                                               : sau_pkg::ST_DATA;
                sau_pkg::ST_DATA:
                    if (sync)
                    begin
                        if (~sel)
                            st_q <= sau_pkg::ST_IDLE;
                        else if (trail)
                        begin
                            cnt_q <= cnt_q + 4'h1;
                            if (last)
                                st_q <= sau_pkg::ST_IDLE;
                        end
                    end
                    else if (step)
                    begin
                        cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
                        if (last)
                            st_q <= par_en_i ? sau_pkg::ST_PAR
                                             : sau_pkg::ST_STOP;
                    end
                sau_pkg::ST_PAR:
                    if (step)
                        st_q <= sau_pkg::ST_STOP;
                sau_pkg::ST_STOP:
                    if (done)
                        st_q <= sau_pkg::ST_IDLE;
                    else if (step)
                        cnt_q <= 4'h1;
                default:
                    st_q <= sau_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            ph_q <= 1'b0;
        else if (st_q == sau_pkg::ST_IDLE)
            ph_q <= go_r;
        else if (tick)
            ph_q <= ~ph_q;
    end

    // ==========================================================
    // transmit holding word and shifter
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            tx_ready_o <= 1'b1;
            hold_q     <= 9'h000;
            sh_q       <= 9'h000;
        end
        else if (load)
        begin
            tx_ready_o <= 1'b1;
            sh_q       <= tx_ready_o ? `SAU_ONES9 : hold_q;
        end
        else if (tx_valid_i & tx_ready_o)
        begin
            tx_ready_o <= 1'b0;
            hold_q     <= tx_data_i;
        end
    end

    always_comb
    begin
        case (st_q)
            sau_pkg::ST_START: ubit = 1'b0;
            sau_pkg::ST_DATA:  ubit = sh_q[bidx(cnt_q)];
            sau_pkg::ST_PAR:   ubit = partx;
            default:           ubit = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            sdo_o <= 1'b1;
        else if (uart)
            sdo_o <= (CH_ODD | ubit) ^ inv;
        else if (load & ~cpha_i)
            sdo_o <= (tx_ready_o | hold_q[bidx(4'h0)]) ^ inv;
        else if (st_q == sau_pkg::ST_DATA & ~cpha_i & trail & ~last)
            sdo_o <= sh_q[bidx(cnt_q + 4'h1)] ^ inv;
        else if (st_q == sau_pkg::ST_DATA & cpha_i & lead)
            sdo_o <= sh_q[bidx(cnt_q)] ^ inv;
        else if (st_q == sau_pkg::ST_IDLE)
            sdo_o <= 1'b1 ^ inv;
    end

    // ==========================================================
    // master serial clock
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            sck_o    <= 1'b0;
            sck_oe_o <= 1'b0;
        end
        else
        begin
            sck_oe_o <= sync & ~slave;
            if (~sync | slave | st_q != sau_pkg::ST_DATA)
                sck_o <= cpol_i;
            else if (tick)
                sck_o <= ~sck_o;
        end
    end

    // ==========================================================
    // receive capture
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            rxs_q   <= 9'h000;
            par_q   <= 1'b0;
            stopb_q <= 1'b1;
            fin_q   <= 1'b0;
        end
        else
        begin
            fin_q <= done & (sync | CH_ODD);
            if (st_q == sau_pkg::ST_IDLE)
                rxs_q <= 9'h000;
            else if (st_q == sau_pkg::ST_DATA &
                     (sync ? samp : step))
                rxs_q[bidx(cnt_q)] <= rxl;
            if (st_q == sau_pkg::ST_PAR & step)
                par_q <= rxl;
            if (st_q == sau_pkg::ST_STOP & step)
                stopb_q <= rxl;
        end
    end

    assign rx_in.valid = fin_q;
    assign rx_in.data  = rxs_q & mask;
    assign rx_out.ready = rx_ready_i;
    assign rx_data_o   = rx_out.data;
    assign rx_valid_o  = rx_out.valid;

    sau_fifo2 #(.W(9)) u_rxbuf (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .in_if     (rx_in),
        .out_if    (rx_out)
    );

    // ==========================================================
    // error flags and interrupts
    always_comb
    begin
        eset = 3'h0;
        eset[`SAU_ERR_FRM] = fin_q & uart & ~stopb_q;
        eset[`SAU_ERR_PAR] = fin_q & uart & par_en_i &
                             (^rx_in.data ^ par_q ^ par_odd_i);
        eset[`SAU_ERR_OVR] = fin_q & ~rx_in.ready;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            err_o     <= 3'h0;
            err_irq_o <= 1'b0;
            irq_o     <= 1'b0;
        end
        else
        begin
            err_o     <= (err_o & ~err_clr_i) | eset;
            err_irq_o <= |eset;
            irq_o     <= irq_sel_i ? load : (fin_q | tx_end);
        end
    end

    // ==========================================================
    // lin break, wakeup, sync field
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            brk_q             <= 5'h00;
            lin_break_field_o <= 1'b0;
            wakeup_o          <= 1'b0;
            lin_rx_o          <= 1'b1;
        end
        else
        begin
            lin_rx_o <= rxl;
            wakeup_o <= go_r & wake_en_i & st_q == sau_pkg::ST_IDLE;
            lin_break_field_o <= tick & ~rxl & uart & CH_ODD &
                (brk_q == `SAU_BRK_HALVES - 5'h01);
            if (rxl | ~uart)
                brk_q <= 5'h00;
            else if (tick & brk_q != `SAU_BRK_HALVES)
                brk_q <= brk_q + 5'h01;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            arm_q       <= 1'b0;
            falls_q     <= 3'h0;
            meas_q      <= '0;
            sync_val_o  <= '0;
            sync_done_o <= 1'b0;
        end
        else
        begin
            sync_done_o <= 1'b0;
            if (lin_break_field_o)
            begin
                arm_q   <= 1'b1;
                falls_q <= 3'h0;
                meas_q  <= '0;
            end
            else if (arm_q)
            begin
                if (falls_q != 3'h0)
                    meas_q <= meas_q + MW'(1);
                if (rx_fall)
                begin
                    falls_q <= falls_q + 3'h1;
                    if (falls_q + 3'h1 == `SAU_SYNC_FALLS)
                    begin
                        arm_q       <= 1'b0;
                        sync_val_o  <= meas_q + MW'(1);
                        sync_done_o <= 1'b1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    sck_tick_a: assert property (
        $changed(sck_o) && sck_oe_o && $past(st_q) == sau_pkg::ST_DATA
        |-> $past(tick)) else $error("sck moved without a tick");
    rx_only_a: assert property (
        uart && CH_ODD |=> sdo_o == (1'b1 ^ $past(inv)))
        else $error("receive-only channel drove data");
    ovr_set_a: assert property (
        fin_q && !rx_in.ready |=> err_o[`SAU_ERR_OVR])
        else $error("overrun not flagged");
    ovr_hold_a: assert property (
        err_o[`SAU_ERR_OVR] && !err_clr_i[`SAU_ERR_OVR]
        |=> err_o[`SAU_ERR_OVR]) else $error("overrun flag dropped");
    end_irq_a: assert property (
        fin_q && !irq_sel_i |=> irq_o) else $error("no end interrupt");
    frame_err_a: assert property (
        fin_q && uart && !stopb_q |=> err_o[`SAU_ERR_FRM] ##0 err_irq_o)
        else $error("framing error missed");
    sck_idle_a: assert property (
        st_q == sau_pkg::ST_IDLE |=> sck_o == $past(cpol_i))
        else $error("idle clock level wrong");
    ssel_gate_a: assert property (
        spi4 && s2_q[0] && st_q == sau_pkg::ST_DATA
        |=> st_q == sau_pkg::ST_IDLE) else $error("unselected slave busy");
endmodule
`default_nettype wire

// ### hw/sau_defs.svh
/*
 * bit counts, error flag positions and lin timing for the serial channel.
 * assumes nothing; definitions only.
 */
`ifndef SAU_DEFS_SVH
`define SAU_DEFS_SVH
`define SAU_BITS7      4'd7
`define SAU_BITS8      4'd8
`define SAU_BITS9      4'd9
`define SAU_ERR_FRM    0
`define SAU_ERR_PAR    1
`define SAU_ERR_OVR    2
`define SAU_BRK_HALVES 5'd22
`define SAU_SYNC_FALLS 3'd5
`define SAU_ONES9      9'h1ff
`endif

// ### hw/sau_pkg.sv
/*
 * types of the serial channel: modes, lengths, sequencer states.
 * assumes the users write every use as sau_pkg::name.
 */
`default_nettype none
package sau_pkg;
    typedef enum logic [1:0] {MODE_UART, MODE_3W, MODE_4W} sau_mode_t;
    typedef enum logic [1:0] {LEN_7, LEN_8, LEN_9} sau_len_t;
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP}
        sau_st_t;
endpackage
`default_nettype wire

// ### hw/sau_stream_if.sv
/*
 * valid/ready word stream between the channel and its receive buffer.
 * assumes both ends share one clock.
 */
`default_nettype none
interface sau_stream_if #(parameter int W = 9);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### hw/sau_baud.sv
/*
 * prescaler and per-channel divider giving one tick per half bit.
 * assumes prs_i and div_i are held steady during a frame.
 */
`default_nettype none
module sau_baud #(
    parameter int PRS_W = 4,
    parameter int DIV_W = 7
) (
    input  wire logic             sys_clk_i,
    input  wire logic             srst_i,
    input  wire logic             restart_i,
    input  wire logic             run_i,
    input  wire logic [PRS_W-1:0] prs_i,
    input  wire logic [DIV_W-1:0] div_i,
    output var  logic             tick_o
);
    localparam int PW = 1 << PRS_W;
    logic [PW-1:0]    prs_q;
    logic [DIV_W-1:0] div_q;
    logic             hit;
    logic             fire;

    // ==========================================================
    // prescaler then divider
    assign hit  = prs_q == PW'((PW'(1) << prs_i) - PW'(1));
    assign fire = hit & (div_q == div_i);

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i | restart_i | ~run_i)
        begin
            prs_q  <= '0;
            div_q  <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            prs_q  <= hit ? '0 : prs_q + PW'(1);
            if (hit)
                div_q <= fire ? '0 : div_q + DIV_W'(1);
            tick_o <= fire;
        end
    end
endmodule
`default_nettype wire

// ### hw/sau_fifo2.sv
/*
 * two-entry receive buffer, head and tail held in flops.
 * assumes one clock; the reader may stall as long as it likes.
 */
`default_nettype none
module sau_fifo2 #(
    parameter int W = 9
) (
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    sau_stream_if.snk in_if,
    sau_stream_if.src out_if
);
    logic [W-1:0] head_q;
    logic [W-1:0] tail_q;
    logic         head_v_q;
    logic         tail_v_q;
    logic         push;
    logic         pop;

    // ==========================================================
    // handshakes
    assign in_if.ready  = ~tail_v_q;
    assign out_if.valid = head_v_q;
    assign out_if.data  = head_q;
    assign push         = in_if.valid & ~tail_v_q;
    assign pop          = out_if.ready & head_v_q;

    // ==========================================================
    // occupancy
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
        end
        else if (pop)
        begin
            head_v_q <= tail_v_q | push;
            tail_v_q <= 1'b0;
        end
        else if (push)
        begin
            head_v_q <= 1'b1;
            tail_v_q <= head_v_q;
        end
    end

    // ==========================================================
    // storage
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            head_q <= '0;
            tail_q <= '0;
        end
        else
        begin
            if (pop)
                head_q <= tail_v_q ? tail_q : in_if.data;
            else if (push & ~head_v_q)
                head_q <= in_if.data;
            if (push & head_v_q & ~pop)
                tail_q <= in_if.data;
        end
    end
endmodule
`default_nettype wire

// ### sim/sau_uart_peer.sv
/*
 * uart peer model: drives frames onto the channel's serial input.
 * assumes one shared clock; the line idles high unless inverted.
 */
`default_nettype none
module sau_uart_peer #(
    parameter int BIT = 8
) (
    input  wire logic clk_i,
    output var  logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_o = 1'b1;
    // ========================================
    // line driving
    task automatic put(input logic b, input int n);
        line_o = b;
        repeat (n) @(negedge clk_i);
    endtask
    task automatic send(input logic [8:0] d, input int nb, input logic msb,
                        input logic inv, input logic pe, input logic pb,
                        input logic sb);
        int i;
        put(1'b0 ^ inv, BIT);
        for (i = 0; i < nb; i++)
            put((msb ? d[nb-1-i] : d[i]) ^ inv, BIT);
        if (pe)
            put(pb ^ inv, BIT);
        put(sb ^ inv, BIT);
        line_o = 1'b1 ^ inv;
    endtask
endmodule
`default_nettype wire

// ### sim/serial_array_unit_channels_tb_top.sv
/*
 * bench for one odd channel, as receive-only uart and as 4-wire slave, fed by the peer model.
 * assumes the channel and the peer share sys_clk_i.
 */
`default_nettype none
module serial_array_unit_channels_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0, srst_i = 1'b1, msb = 0, inv = 0, pe = 0, po = 0;
    logic rdy = 0, brk = 0, wk = 0, eirq = 0, rxv, lbrk, wko, eio, line;
    logic [2:0] clr = 3'h0, err;
    logic [8:0] rxd;
    sau_pkg::sau_len_t len = sau_pkg::LEN_8;
    logic cpol = 0, cpha = 0, irqs = 0, wen = 1, sck = 0, ssel_n = 1, sd = 0;
    logic irq, sdo, sko, soe, txr, lrx, sdn;
    logic [3:0] prs = 4'h0;
    logic [6:0] div = 7'h03;
    logic [15:0] sval;
    sau_pkg::sau_mode_t mode = sau_pkg::MODE_UART;
    int errors = 0, checks = 0, nirq = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    sau_uart_peer #(.BIT(8)) peer (.clk_i(sys_clk_i), .line_o(line));
    sau_top #(.CH_ODD(1'b1)) DUT (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .mode_i(mode),
        .master_i(1'b0), .len_i(len), .msb_first_i(msb), .cpol_i(cpol),
        .cpha_i(cpha), .invert_i(inv), .par_en_i(pe), .par_odd_i(po),
        .stop2_i(1'b0), .irq_sel_i(irqs), .wake_en_i(wen), .prs_i(prs),
        .div_i(div), .tx_data_i(9'h000), .tx_valid_i(1'b0), .tx_ready_o(txr),
        .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rdy), .err_clr_i(clr),
        .err_o(err), .err_irq_o(eio), .irq_o(irq), .sdi_i(line), .sdo_o(sdo),
        .sck_i(sck), .sck_o(sko), .sck_oe_o(soe), .ssel_n_i(ssel_n),
        .lin_rx_o(lrx), .lin_break_field_o(lbrk), .wakeup_o(wko),
        .sync_val_o(sval), .sync_done_o(sdn));
    always @(posedge sys_clk_i)
    begin
        if (lbrk)
            brk <= 1'b1;
        if (wko)
            wk <= 1'b1;
        if (eio)
            eirq <= 1'b1;
        if (irq)
            nirq <= nirq + 1;
        if (sdn)
            sd <= 1'b1;
    end
    // ========================================
    // access tasks
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic pop(input logic [8:0] exp);
        int n;
        n = 0;
        while (rxv !== 1'b1 && n < 400)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        check({8'h00, rxv}, 9'h001);
        check(rxd, exp);
        rdy = 1'b1;
        @(negedge sys_clk_i);
        rdy = 1'b0;
        @(negedge sys_clk_i);
    endtask
    task automatic flush(input logic [2:0] exp);
        repeat (12) @(negedge sys_clk_i);
        rdy = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        rdy = 1'b0;
        check({8'h00, rxv}, 9'h000);
        check({6'h00, err}, {6'h00, exp});
        clr = 3'h7;
        @(negedge sys_clk_i);
        clr = 3'h0;
        @(negedge sys_clk_i);
        check({6'h00, err}, 9'h000);
    endtask
    task automatic spi_byte(input logic [7:0] d);
        int i;
        for (i = 7; i >= 0; i--)
        begin
            if (!cpha)
                peer.put(d[i], 4);
            else
                repeat (4) @(negedge sys_clk_i);
            sck = ~cpol;
            if (cpha)
                peer.put(d[i], 0);
            repeat (4) @(negedge sys_clk_i);
            sck = cpol;
        end
    endtask
    task automatic spi_frame(input logic [7:0] d);
        int n0;
        n0 = nirq;
        ssel_n = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        check(9'(nirq - n0), 9'h001);
        spi_byte(d);
        repeat (6) @(negedge sys_clk_i);
        ssel_n = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        pop({1'b0, d});
    endtask
    task automatic report_and_stop;
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ========================================
    // tests
    initial
    begin
        int k;
        logic [8:0] d;
        repeat (2) @(negedge sys_clk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        check({4'h0, lrx, sdo, sko, soe, txr}, 9'h019);
        for (k = 0; k < 6; k++)
        begin
            len = sau_pkg::sau_len_t'(k % 3);
            msb = k >= 3;
            d = 9'h1a5 & ~(9'h1ff << (7 + k % 3));
            peer.send(d, 7 + k % 3, msb, 1'b0, 1'b0, 1'b0, 1'b1);
            pop(d);
        end
        check({8'h00, wk}, 9'h001);
        check(9'(nirq > 0), 9'h001);
        msb = 1'b0;
        len = sau_pkg::LEN_8;
        pe = 1'b1;
        for (k = 0; k < 2; k++)
        begin
            po = k[0];
            prs = k[3:0];
            div = k[0] ? 7'h01 : 7'h03;
            peer.send(9'h0b3, 8, 1'b0, 1'b0, 1'b1, ^9'h0b3 ^ po, 1'b1);
            pop(9'h0b3);
            peer.send(9'h0b3, 8, 1'b0, 1'b0, 1'b1, ~(^9'h0b3 ^ po), 1'b1);
            flush(3'h2);
        end
        pe = 1'b0;
        prs = 4'h0;
        div = 7'h03;
        peer.send(9'h05a, 8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        flush(3'h1);
        check({8'h00, eirq}, 9'h001);
        for (k = 1; k < 4; k++)
            peer.send(9'(9'h011 * k), 8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        repeat (12) @(negedge sys_clk_i);
        check({6'h00, err}, 9'h004);
        pop(9'h011);
        pop(9'h022);
        flush(3'h4);
        inv = 1'b1;
        peer.put(1'b0, 16);
        peer.send(9'h03c, 8, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        pop(9'h03c);
        inv = 1'b0;
        peer.put(1'b1, 16);
        peer.put(1'b0, 8 * 13);
        peer.put(1'b1, 16);
        flush(3'h1);
        check({8'h00, brk}, 9'h001);
        peer.send(9'h055, 8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        pop(9'h055);
        check(sval[8:0], 9'h040);
        check({8'h00, sd}, 9'h001);
        mode = sau_pkg::MODE_4W;
        msb = 1'b1;
        irqs = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        spi_frame(8'hc6);
        cpol = 1'b1;
        cpha = 1'b1;
        sck = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        check({8'h00, sko}, 9'h001);
        spi_frame(8'h3a);
        check({8'h00, soe}, 9'h000);
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
